// ==== src/link_node_status_words.v ====
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps
`include "link_status_regs.vh"

module link_node_status_words (
  // Clock, reset, enable
  input  wire                      clk,
  input  wire                      reset,
  input  wire                      clkEn,
  // Register port
  input  wire [`LNS_ADDR_W-1:0]    regAddr,
  input  wire [`LNS_DATA_W-1:0]    regWrData,
  input  wire                      regWrite,
  input  wire                      regRead,
  output reg  [`LNS_DATA_W-1:0]    regRdData,
  // Token network status, level 1 in the upper 16 bits
  input  wire [31:0]               tokLinkActive,
  input  wire [31:0]               tokCommError,
  input  wire [31:0]               tokCtrlError,
  input  wire [31:0]               tokRun,
  // Loop network status by registration, level 1 in the upper 32 bits
  input  wire [63:0]               loopCtrlError,
  input  wire [63:0]               loopRun,
  // Peer link status, single-level numbering
  input  wire [31:0]               peerRun,
  input  wire [31:0]               peerError,
  // Peer link status, multilevel numbering
  input  wire [15:0]               peerRunL0,
  input  wire [15:0]               peerErrorL0,
  input  wire [15:0]               peerRunL1,
  input  wire [15:0]               peerErrorL1,
  // Interrupt
  output wire                      irq
);

  //////////////////////////////////////////////////////////////////////////////
  // Address decode

  wire [9:0] regIdx   = regAddr[`LNS_ADDR_W-1:2];
  wire       aligned  = (regAddr[1:0] == `LNS_WORD_LSB_PAD);

  wire selCfg   = aligned && (regIdx == `LNS_IDX_CONFIG);
  wire selIrqSt = aligned && (regIdx == `LNS_IDX_IRQ_STATUS);
  wire selIrqMk = aligned && (regIdx == `LNS_IDX_IRQ_MASK);

  //////////////////////////////////////////////////////////////////////////////
  // Configuration

  reg [`LNS_CFG_W-1:0] cfg_q;

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      cfg_q <= `LNS_CFG_RESET;
    end else if (clkEn && regWrite && selCfg) begin
      cfg_q <= regWrData[`LNS_CFG_W-1:0];
    end
  end

  wire netLoop   = cfg_q[`LNS_CFG_NET_LOOP];
  wire peerMulti = cfg_q[`LNS_CFG_PEER_MULTI];

  //////////////////////////////////////////////////////////////////////////////
  // Live word images

  // Slots 0-3 level 0, 4-7 level 1, 8-11 peer words in rising index order
  wire [`LNS_NUM_WORDS*16-1:0] liveWords;
  wire [127:0]                 tokWords;
  wire [63:0]                  peerWords;

  genvar lv;
  generate
    for (lv = 0; lv < 2; lv = lv + 1) begin : gLevel
      node_status_pack #(
        .NODES (16)
      ) uPack (
        .linkActive (tokLinkActive[lv*16 +: 16]),
        .commError  (tokCommError[lv*16 +: 16]),
        .ctrlError  (tokCtrlError[lv*16 +: 16]),
        .runMode    (tokRun[lv*16 +: 16]),
        .nibbles    (tokWords[lv*64 +: 64])
      );
    end
  endgenerate

  genvar w;
  generate
    for (w = 0; w < 8; w = w + 1) begin : gNetWord
      wire [15:0] loopWord;
      assign loopWord[`LNS_HALF_LO +: `LNS_HALF_W] = loopCtrlError[w*8 +: 8];
      assign loopWord[`LNS_HALF_HI +: `LNS_HALF_W] = loopRun[w*8 +: 8];
      // Network kind is chosen by software; both share the same words
      assign liveWords[w*16 +: 16] = netLoop ? loopWord : tokWords[w*16 +: 16];
    end
  endgenerate

  peer_unit_map uPeer (
    .multiLevel (peerMulti),
    .unitRun    (peerRun),
    .unitError  (peerError),
    .l0Run      (peerRunL0),
    .l0Error    (peerErrorL0),
    .l1Run      (peerRunL1),
    .l1Error    (peerErrorL1),
    .words      (peerWords)
  );

  assign liveWords[`LNS_SLOT_PEER*16 +: 64] = peerWords;

  //////////////////////////////////////////////////////////////////////////////
  // Status word registers

  // Sampled every enabled cycle; there is no write path into them
  reg [15:0] word_q [0:`LNS_NUM_WORDS-1];

  genvar s;
  generate
    for (s = 0; s < `LNS_NUM_WORDS; s = s + 1) begin : gWordReg
      always @(posedge clk or posedge reset) begin
        if (reset) begin
          word_q[s] <= 16'h0000;
        end else if (clkEn) begin
          word_q[s] <= liveWords[s*16 +: 16];
        end
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // Event detection

  // A word change after a mode switch may raise spurious events, all in one cycle
  wire [15:0] netErrMask = netLoop ? `LNS_LOOP_ERR_MASK : `LNS_TOKEN_ERR_MASK;
  wire [15:0] netLnkMask = netLoop ? 16'h0000 : `LNS_TOKEN_LINK_MASK;

  wire [`LNS_NUM_WORDS-1:0] errRise;
  wire [`LNS_NUM_WORDS-1:0] linkFall;

  genvar e;
  generate
    for (e = 0; e < `LNS_NUM_WORDS; e = e + 1) begin : gEvent
      wire [15:0] errMask = (e >= `LNS_SLOT_PEER) ? `LNS_PEER_ERR_MASK : netErrMask;
      wire [15:0] lnkMask = (e >= `LNS_SLOT_PEER) ? 16'h0000 : netLnkMask;
      wire [15:0] nextW   = liveWords[e*16 +: 16];
      assign errRise[e]  = |(nextW & ~word_q[e] & errMask);
      assign linkFall[e] = |(~nextW & word_q[e] & lnkMask);
    end
  endgenerate

  wire [`LNS_IRQ_W-1:0] irqEvent;
  assign irqEvent[`LNS_IRQ_L0_ERR]    = |errRise[`LNS_SLOT_L0 +: `LNS_WORDS_PER_GROUP];
  assign irqEvent[`LNS_IRQ_L1_ERR]    = |errRise[`LNS_SLOT_L1 +: `LNS_WORDS_PER_GROUP];
  assign irqEvent[`LNS_IRQ_PEER_ERR]  = |errRise[`LNS_SLOT_PEER +: `LNS_WORDS_PER_GROUP];
  assign irqEvent[`LNS_IRQ_LINK_LOST] = |linkFall;

  //////////////////////////////////////////////////////////////////////////////
  // Interrupt status and mask

  reg [`LNS_IRQ_W-1:0] irqStatus_q;
  reg [`LNS_IRQ_W-1:0] irqMask_q;
  reg [`LNS_IRQ_W-1:0] irqStatus_d;

  always @* begin
    irqStatus_d = irqStatus_q;
    if (regWrite && selIrqSt) begin
      irqStatus_d = irqStatus_d & ~regWrData[`LNS_IRQ_W-1:0];
    end
    // Set after clear so a same-cycle event is kept
    irqStatus_d = irqStatus_d | irqEvent;
  end

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      irqStatus_q <= `LNS_IRQ_RESET;
      irqMask_q   <= `LNS_IRQ_RESET;
    end else if (clkEn) begin
      irqStatus_q <= irqStatus_d;
      if (regWrite && selIrqMk) begin
        irqMask_q <= regWrData[`LNS_IRQ_W-1:0];
      end
    end
  end

  assign irq = |(irqStatus_q & irqMask_q);

  //////////////////////////////////////////////////////////////////////////////
  // Read path

  reg [`LNS_DATA_W-1:0] rdMux;

  always @* begin
    rdMux = {`LNS_DATA_W{1'b0}};
    if (aligned) begin
      case (regIdx)
        `LNS_IDX_L0_W0:      rdMux[15:0] = word_q[0];
        `LNS_IDX_L0_W1:      rdMux[15:0] = word_q[1];
        `LNS_IDX_L0_W2:      rdMux[15:0] = word_q[2];
        `LNS_IDX_L0_W3:      rdMux[15:0] = word_q[3];
        `LNS_IDX_L1_W0:      rdMux[15:0] = word_q[4];
        `LNS_IDX_L1_W1:      rdMux[15:0] = word_q[5];
        `LNS_IDX_L1_W2:      rdMux[15:0] = word_q[6];
        `LNS_IDX_L1_W3:      rdMux[15:0] = word_q[7];
        `LNS_IDX_PEER_W3:    rdMux[15:0] = word_q[8];
        `LNS_IDX_PEER_W2:    rdMux[15:0] = word_q[9];
        `LNS_IDX_PEER_W1:    rdMux[15:0] = word_q[10];
        `LNS_IDX_PEER_W0:    rdMux[15:0] = word_q[11];
        `LNS_IDX_CONFIG:     rdMux[`LNS_CFG_W-1:0] = cfg_q;
        `LNS_IDX_IRQ_STATUS: rdMux[`LNS_IRQ_W-1:0] = irqStatus_q;
        `LNS_IDX_IRQ_MASK:   rdMux[`LNS_IRQ_W-1:0] = irqMask_q;
        default:             rdMux = {`LNS_DATA_W{1'b0}};
      endcase
    end
  end

  // Data is valid only in the cycle after the read strobe
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      regRdData <= {`LNS_DATA_W{1'b0}};
    end else if (clkEn) begin
      regRdData <= regRead ? rdMux : {`LNS_DATA_W{1'b0}};
    end
  end

endmodule // link_node_status_words

// ==== src/link_status_regs.vh ====
`ifndef LINK_STATUS_REGS_VH
`define LINK_STATUS_REGS_VH

// Register indices; byte address is four times the index
`define LNS_IDX_L0_W0        10'h0EE
`define LNS_IDX_L0_W1        10'h0EF
`define LNS_IDX_L0_W2        10'h0F0
`define LNS_IDX_L0_W3        10'h0F1
`define LNS_IDX_L1_W0        10'h0F2
`define LNS_IDX_L1_W1        10'h0F3
`define LNS_IDX_L1_W2        10'h0F4
`define LNS_IDX_L1_W3        10'h0F5
`define LNS_IDX_PEER_W3      10'h0F7
`define LNS_IDX_PEER_W2      10'h0F8
`define LNS_IDX_PEER_W1      10'h0F9
`define LNS_IDX_PEER_W0      10'h0FA
`define LNS_IDX_CONFIG       10'h100
`define LNS_IDX_IRQ_STATUS   10'h101
`define LNS_IDX_IRQ_MASK     10'h102

// Bus geometry
`define LNS_ADDR_W           12
`define LNS_DATA_W           32
`define LNS_WORD_W           16
`define LNS_NUM_WORDS        12
`define LNS_WORD_LSB_PAD     2'h0

// Word array slots
`define LNS_SLOT_L0          0
`define LNS_SLOT_L1          4
`define LNS_SLOT_PEER        8
`define LNS_WORDS_PER_GROUP  4

// Four-bit node group layout
`define LNS_NIB_LINK         3
`define LNS_NIB_COMM         2
`define LNS_NIB_CTRL         1
`define LNS_NIB_RUN          0
`define LNS_NIB_W            4

// Loop and peer word halves
`define LNS_HALF_W           8
`define LNS_HALF_LO          0
`define LNS_HALF_HI          8

// Error and link masks for event detection
`define LNS_TOKEN_ERR_MASK   16'h6666
`define LNS_TOKEN_LINK_MASK  16'h8888
`define LNS_LOOP_ERR_MASK    16'h00FF
`define LNS_PEER_ERR_MASK    16'hFF00

// Config register fields
`define LNS_CFG_NET_LOOP     0
`define LNS_CFG_PEER_MULTI   1
`define LNS_CFG_W            2
`define LNS_CFG_RESET        2'h0

// Interrupt status and mask fields
`define LNS_IRQ_L0_ERR       0
`define LNS_IRQ_L1_ERR       1
`define LNS_IRQ_PEER_ERR     2
`define LNS_IRQ_LINK_LOST    3
`define LNS_IRQ_W            4
`define LNS_IRQ_RESET        4'h0

`endif

// ==== src/node_status_pack.v ====
`timescale 1ns/1ps
`include "link_status_regs.vh"

module node_status_pack #(
  parameter NODES = 16
) (
  // Per-node status from the link interface
  input  wire [NODES-1:0]   linkActive,
  input  wire [NODES-1:0]   commError,
  input  wire [NODES-1:0]   ctrlError,
  input  wire [NODES-1:0]   runMode,
  // Packed words, node 0 in the lowest group of the first word
  output wire [NODES*4-1:0] nibbles
);

  genvar n;
  generate
    for (n = 0; n < NODES; n = n + 1) begin : gNode
      assign nibbles[n*`LNS_NIB_W+`LNS_NIB_LINK] = linkActive[n];
      assign nibbles[n*`LNS_NIB_W+`LNS_NIB_COMM] = commError[n];
      assign nibbles[n*`LNS_NIB_W+`LNS_NIB_CTRL] = ctrlError[n];
      assign nibbles[n*`LNS_NIB_W+`LNS_NIB_RUN]  = runMode[n];
    end
  endgenerate

endmodule // node_status_pack

// ==== src/peer_unit_map.v ====
`timescale 1ns/1ps
`include "link_status_regs.vh"

module peer_unit_map (
  // Configuration
  input  wire        multiLevel,
  // Single-level units 0-31
  input  wire [31:0] unitRun,
  input  wire [31:0] unitError,
  // Multilevel units 0-15 per level
  input  wire [15:0] l0Run,
  input  wire [15:0] l0Error,
  input  wire [15:0] l1Run,
  input  wire [15:0] l1Error,
  // Slot 0 is the lowest word index and carries the top unit group
  output wire [63:0] words
);

  // Both layouts put unit groups of eight into words in the same order
  wire [31:0] runSel = multiLevel ? {l1Run, l0Run} : unitRun;
  wire [31:0] errSel = multiLevel ? {l1Error, l0Error} : unitError;

  genvar k;
  generate
    for (k = 0; k < 4; k = k + 1) begin : gWord
      // Slot 3-k holds unit group k
      assign words[(3-k)*16+`LNS_HALF_LO +: `LNS_HALF_W] = runSel[k*8 +: 8];
      assign words[(3-k)*16+`LNS_HALF_HI +: `LNS_HALF_W] = errSel[k*8 +: 8];
    end
  endgenerate

endmodule // peer_unit_map

// ==== test/link_units_model.sv ====
`timescale 1ns/1ps

module link_units_model (
  // Clock
  input  logic        clk,
  // Token network
  output logic [31:0] tokLinkActive,
  output logic [31:0] tokCommError,
  output logic [31:0] tokCtrlError,
  output logic [31:0] tokRun,
  // Loop network
  output logic [63:0] loopCtrlError,
  output logic [63:0] loopRun,
  // Peer link
  output logic [31:0] peerRun,
  output logic [31:0] peerError,
  output logic [15:0] peerRunL0,
  output logic [15:0] peerErrorL0,
  output logic [15:0] peerRunL1,
  output logic [15:0] peerErrorL1
);
  // All units start idle so the first sample after reset is clean
  initial begin
    {tokLinkActive, tokCommError, tokCtrlError, tokRun} = 128'h0;
    {loopCtrlError, loopRun} = 128'h0;
    {peerRun, peerError, peerRunL0, peerErrorL0, peerRunL1, peerErrorL1} = 128'h0;
  end

  task automatic setTok(input logic [31:0] l, c, e, r);
    @(posedge clk);
    {tokLinkActive, tokCommError, tokCtrlError, tokRun} <= {l, c, e, r};
  endtask

  task automatic setLoop(input logic [63:0] e, r);
    @(posedge clk);
    {loopCtrlError, loopRun} <= {e, r};
  endtask

  task automatic setPeer(input logic [31:0] r, e, input logic [15:0] r0, e0, r1, e1);
    @(posedge clk);
    {peerRun, peerError, peerRunL0, peerErrorL0, peerRunL1, peerErrorL1} <= {r, e, r0, e0, r1, e1};
  endtask
endmodule // link_units_model

// ==== test/link_node_status_words_properties.sv ====
`timescale 1ns/1ps

module link_node_status_words_checker (
  // Clock and register port
  input logic        clk,
  input logic        reset,
  input logic        clkEn,
  input logic [11:0] regAddr,
  input logic [31:0] regWrData,
  input logic        regWrite,
  input logic        regRead,
  input logic [31:0] regRdData,
  // Link status and interrupt
  input logic [31:0] tokLinkActive,
  input logic [31:0] tokCommError,
  input logic [31:0] tokCtrlError,
  input logic [31:0] tokRun,
  input logic [63:0] loopCtrlError,
  input logic [63:0] loopRun,
  input logic [31:0] peerRun,
  input logic [31:0] peerError,
  input logic [15:0] peerRunL0,
  input logic [15:0] peerErrorL0,
  input logic [15:0] peerRunL1,
  input logic [15:0] peerErrorL1,
  input logic        irq
);
  wire [383:0] allIn = {tokLinkActive, tokCommError, tokCtrlError, tokRun, loopCtrlError,
                        loopRun, peerRun, peerError, peerRunL0, peerErrorL0, peerRunL1, peerErrorL1};
  wire [9:0]   idx = regAddr[11:2];
  wire         cfgWr = regWrite && clkEn && regAddr == 12'h400;
  reg  [383:0] allIn_q;
  reg  [15:0]  exp_q;
  reg  [1:0]   cfg_q;
  reg  [3:0]   mask_q;
  reg          live_q;
  reg          cfgWr_q;
  // Words lag inputs by one sample, so only stable inputs give a checkable read
  wire calm = live_q && !cfgWr_q && allIn == allIn_q;
  wire rdOk = regRead && clkEn && regAddr[1:0] == 2'h0 && calm;
  wire lvlRd = rdOk && idx >= 10'h0EE && idx <= 10'h0F5;
  wire peerRd = rdOk && idx >= 10'h0F7 && idx <= 10'h0FA;

  function automatic logic [15:0] expWord(input logic [9:0] i);
    int k;
    expWord = 16'h0;
    if (i >= 10'h0EE && i <= 10'h0F5) begin
      k = i - 10'h0EE;
      if (cfg_q[0])
        expWord = {loopRun[8*k+:8], loopCtrlError[8*k+:8]};
      else
        for (int n = 0; n < 4; n++)
          expWord[4*n+:4] = {tokLinkActive[4*k+n], tokCommError[4*k+n],
                             tokCtrlError[4*k+n], tokRun[4*k+n]};
    end else if (i >= 10'h0F7 && i <= 10'h0FA) begin
      k = 10'h0FA - i;
      if (!cfg_q[1])
        expWord = {peerError[8*k+:8], peerRun[8*k+:8]};
      else if (k < 2)
        expWord = {peerErrorL0[8*k+:8], peerRunL0[8*k+:8]};
      else
        expWord = {peerErrorL1[8*k-16+:8], peerRunL1[8*k-16+:8]};
    end
  endfunction

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      cfg_q <= 2'h0;
      mask_q <= 4'h0;
      live_q <= 1'b0;
      cfgWr_q <= 1'b0;
    end else begin
      allIn_q <= allIn;
      exp_q <= expWord(idx);
      cfgWr_q <= cfgWr;
      live_q <= live_q | clkEn;
      if (cfgWr)
        cfg_q <= regWrData[1:0];
      if (regWrite && clkEn && regAddr == 12'h408)
        mask_q <= regWrData[3:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_token_word_map: assert property (lvlRd && !cfg_q[0] |=> regRdData == {16'h0, exp_q})
    else $error("token status word wrong");
  a_loop_word_map: assert property (lvlRd && cfg_q[0] |=> regRdData == {16'h0, exp_q})
    else $error("loop status word wrong");
  a_peer_single_map: assert property (peerRd && !cfg_q[1] |=> regRdData == {16'h0, exp_q})
    else $error("single level peer word wrong");
  a_peer_multi_map: assert property (peerRd && cfg_q[1] |=> regRdData == {16'h0, exp_q})
    else $error("multilevel peer word wrong");
  a_misaligned_zero: assert property (regRead && clkEn && regAddr[1:0] != 2'h0 |=> regRdData == 32'h0)
    else $error("misaligned read not zero");
  a_rdata_window: assert property (!regRead && clkEn |=> regRdData == 32'h0)
    else $error("read data outside its cycle");
  a_irq_mask_gate: assert property (irq |-> mask_q != 4'h0)
    else $error("irq while all masked");
  a_irq_peer_rise: assert property (live_q && !cfgWr_q && !cfg_q[1] && mask_q[2] && !regWrite && clkEn
                                    && $rose(peerError[0]) |=> irq)
    else $error("peer error rise gave no irq");

  cover property (irq);
  cover property (lvlRd && cfg_q[0]);
  cover property (peerRd && cfg_q[1]);
endmodule // link_node_status_words_checker

bind link_node_status_words link_node_status_words_checker chk (
  .clk(clk), .reset(reset), .clkEn(clkEn), .regAddr(regAddr), .regWrData(regWrData),
  .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .tokLinkActive(tokLinkActive),
  .tokCommError(tokCommError), .tokCtrlError(tokCtrlError), .tokRun(tokRun),
  .loopCtrlError(loopCtrlError), .loopRun(loopRun), .peerRun(peerRun), .peerError(peerError),
  .peerRunL0(peerRunL0), .peerErrorL0(peerErrorL0), .peerRunL1(peerRunL1),
  .peerErrorL1(peerErrorL1), .irq(irq));

// ==== test/link_node_status_words_test.sv ====
`timescale 1ns/1ps

module link_node_status_words_test;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic        clkEn = 1'b1;
  logic        regWrite = 1'b0;
  logic        regRead = 1'b0;
  logic [11:0] regAddr = 12'h0;
  logic [31:0] regWrData = 32'h0;
  wire  [31:0] regRdData, tokLinkActive, tokCommError, tokCtrlError, tokRun, peerRun, peerError;
  wire  [63:0] loopCtrlError, loopRun;
  wire  [15:0] peerRunL0, peerErrorL0, peerRunL1, peerErrorL1;
  wire         irq;
  int          errors = 0;
  int          compares = 0;
  int          cycles = 0;

  always #5 clk = ~clk;

  link_units_model units (.clk(clk), .tokLinkActive(tokLinkActive), .tokCommError(tokCommError),
    .tokCtrlError(tokCtrlError), .tokRun(tokRun), .loopCtrlError(loopCtrlError),
    .loopRun(loopRun), .peerRun(peerRun), .peerError(peerError), .peerRunL0(peerRunL0),
    .peerErrorL0(peerErrorL0), .peerRunL1(peerRunL1), .peerErrorL1(peerErrorL1));

  link_node_status_words dut (.clk(clk), .reset(reset), .clkEn(clkEn), .regAddr(regAddr),
    .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
    .tokLinkActive(tokLinkActive), .tokCommError(tokCommError), .tokCtrlError(tokCtrlError),
    .tokRun(tokRun), .loopCtrlError(loopCtrlError), .loopRun(loopRun), .peerRun(peerRun),
    .peerError(peerError), .peerRunL0(peerRunL0), .peerErrorL0(peerErrorL0),
    .peerRunL1(peerRunL1), .peerErrorL1(peerErrorL1), .irq(irq));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] exp, got);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    {regWrite, regAddr, regWrData} <= {1'b1, a, d};
    @(posedge clk);
    regWrite <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    @(posedge clk);
    {regRead, regAddr} <= {1'b1, a};
    @(posedge clk);
    regRead <= 1'b0;
    #1 check($sformatf("word %h", a), exp, regRdData);
  endtask

  task automatic irqIs(input logic e);
    #1 check("irq", {31'h0, e}, {31'h0, irq});
  endtask

  task automatic settle;
    repeat (3) @(posedge clk);
  endtask

  task automatic tally_and_finish;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      errors++;
      tally_and_finish;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    rd(12'h400, 32'h0);
    rd(12'h404, 32'h0);
    rd(12'h408, 32'h0);
    units.setTok(32'h0000_0001, 32'h0000_0020, 32'h0000_8000, 32'h0001_0000);
    settle;
    rd(12'h3B8, 32'h0000_0008);
    rd(12'h3BC, 32'h0000_0040);
    rd(12'h3C4, 32'h0000_2000);
    rd(12'h3C8, 32'h0000_0001);
    wr(12'h3B8, 32'h0000_FFFF);
    rd(12'h3B8, 32'h0000_0008);
    units.setTok(32'h0, 32'h0000_0020, 32'h0000_8000, 32'h0001_0000);
    settle;
    rd(12'h3B8, 32'h0);
    wr(12'h400, 32'h1);
    units.setLoop(64'h0000_0000_8000_0001, 64'h0000_0080_0000_0000);
    settle;
    rd(12'h3B8, 32'h0000_0001);
    rd(12'h3C4, 32'h0000_0080);
    rd(12'h3C8, 32'h0000_8000);
    units.setPeer(32'h0000_0201, 32'h8000_0000, 16'h0100, 16'h0001, 16'h00FF, 16'h0002);
    settle;
    rd(12'h3E8, 32'h0000_0001);
    rd(12'h3E4, 32'h0000_0002);
    rd(12'h3DC, 32'h0000_8000);
    wr(12'h400, 32'h2);
    settle;
    rd(12'h3E0, 32'h0000_02FF);
    rd(12'h3E4, 32'h0000_0001);
    rd(12'h3E8, 32'h0000_0100);
    rd(12'h3D8, 32'h0);
    rd(12'h3B9, 32'h0);
    // Level 0 errors, peer error and link loss were all posted; level 1 never erred
    rd(12'h404, 32'hD);
    // Mode change may post events, so status is cleared only after it settles
    wr(12'h400, 32'h0);
    units.setPeer(32'h0, 32'h0, 16'h0, 16'h0, 16'h0, 16'h0);
    settle;
    wr(12'h404, 32'hF);
    irqIs(1'b0);
    wr(12'h408, 32'h4);
    units.setPeer(32'h0, 32'h1, 16'h0, 16'h0, 16'h0, 16'h0);
    settle;
    irqIs(1'b1);
    rd(12'h404, 32'h4);
    wr(12'h408, 32'h0);
    irqIs(1'b0);
    wr(12'h408, 32'h4);
    irqIs(1'b1);
    wr(12'h404, 32'h4);
    irqIs(1'b0);
    // Clear and a fresh event in one cycle: the event must survive
    units.setPeer(32'h0, 32'h0, 16'h0, 16'h0, 16'h0, 16'h0);
    settle;
    fork
      units.setPeer(32'h0, 32'h1, 16'h0, 16'h0, 16'h0, 16'h0);
      wr(12'h404, 32'h4);
    join
    irqIs(1'b1);
    // A write while the clock enable is low must leave the mask alone
    @(posedge clk) clkEn <= 1'b0;
    wr(12'h408, 32'h0);
    clkEn <= 1'b1;
    rd(12'h408, 32'h4);
    tally_and_finish;
  end
endmodule // link_node_status_words_test
